// [hw/tlsf_params.svh]
// timing counts, thresholds and widths for the level filter
`ifndef TLSF_PARAMS_SVH
`define TLSF_PARAMS_SVH
`define TLSF_CLK_PERIOD_PS 5000
`define TLSF_LOWER_TRIP_COUNTS 10'h0fa
`define TLSF_UPPER_TRIP_COUNTS 10'h096
`define TLSF_HYST_COUNTS 10'h003
`define TLSF_COUNT_STEP_NS 7000
`define TLSF_COUNT_STEP_CYCLES ((`TLSF_COUNT_STEP_NS * 1000) / `TLSF_CLK_PERIOD_PS)
`define TLSF_HEALTH_PULSE_NS 350000
`define TLSF_HEALTH_PULSE_CYCLES ((`TLSF_HEALTH_PULSE_NS * 1000) / `TLSF_CLK_PERIOD_PS)
`define TLSF_SETTLE_MS 15000
`define TLSF_BURST_PERIOD_MS 100
`define TLSF_INTEG_LIMIT (`TLSF_SETTLE_MS / `TLSF_BURST_PERIOD_MS)
`define TLSF_BURST_MAX_COUNTS 10'h190
`endif

// [hw/tlsf_pkg.sv]
// types for the twin level slosh filter
package tlsf_pkg;
  typedef enum logic [1:0] {TLSF_IDLE, TLSF_HEALTH, TLSF_BURST} tlsf_phase_e;
  typedef logic [9:0] tlsf_count_t;
endpackage

// [hw/tlsf_top.sv]
// twin level decision logic with slosh filters and health pulse
//
// What this block does
// - detection steps counter up; assert at limit
// - non-detection steps counter down, floor zero
// - asserted output releases only at zero
// - steady input changes output after 15s
// - two independent filters, lower and upper
// - strap high filters, low passes directly
// - filter strap sampled every cycle, live
// - lower trip 250, upper trip 150 counts
// - count below threshold means detection
// - three count hysteresis around each threshold
// - burst count advances once per 7us
// - comparisons purely in counts, not time
// - polarity strap sets active level, live
// - both outputs float 350us before burst
// - no timeout on asserted outputs
`timescale 1ns/100ps
`include "tlsf_params.svh"
module tlsf_top
  import tlsf_pkg::*;
#(
  // limit sized for 15 s settle
  parameter int INTEG_LIMIT = `TLSF_INTEG_LIMIT,
  parameter int STEP_CYCLES = `TLSF_COUNT_STEP_CYCLES,
  parameter int HEALTH_CYCLES = `TLSF_HEALTH_PULSE_CYCLES
)
(
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic BURST_START_I,
  input wire logic CHARGE_DONE_I,
  input wire logic FILTER_ENABLE_STRAP_I,
  input wire logic OUTPUT_POLARITY_STRAP_I,
  output logic LOWER_LEVEL_OUTPUT_O,
  output logic LOWER_LEVEL_OUTPUT_OE_O,
  output logic UPPER_LEVEL_OUTPUT_O,
  output logic UPPER_LEVEL_OUTPUT_OE_O,
  output logic BURST_ACTIVE_O,
  output logic [9:0] BURST_COUNT_O
);

  localparam int CW = $clog2(INTEG_LIMIT + 1);
  localparam int SW = $clog2(STEP_CYCLES + 1);
  localparam int HW = $clog2(HEALTH_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////////////
  // burst sequencer: health float, then count until charge done or count reaches 400
  tlsf_phase_e phase_reg;
  tlsf_phase_e phase_next;
  logic [SW-1:0] step_reg;
  logic [SW-1:0] step_next;
  logic [HW-1:0] hb_reg;
  logic [HW-1:0] hb_next;
  tlsf_count_t count_reg;
  tlsf_count_t count_next;
  logic done_pulse;

  always_comb
  begin
    phase_next = phase_reg;
    step_next = step_reg;
    hb_next = hb_reg;
    count_next = count_reg;
    done_pulse = 1'b0;
    unique case (phase_reg)
      TLSF_IDLE:
      begin
        if (BURST_START_I)
        begin
          phase_next = TLSF_HEALTH;
          hb_next = '0;
        end
      end
      TLSF_HEALTH:
      begin
        hb_next = hb_reg + 1'b1;
        if (hb_reg == HW'(HEALTH_CYCLES - 1))
        begin
          phase_next = TLSF_BURST;
          step_next = '0;
          count_next = '0;
        end
      end
      TLSF_BURST:
      begin
        if (step_reg == SW'(STEP_CYCLES - 1))
        begin
          step_next = '0;
          if (count_reg != `TLSF_BURST_MAX_COUNTS)
          begin
            count_next = count_reg + 10'h001;
          end
        end
        else
        begin
          step_next = step_reg + 1'b1;
        end
        // saturating count bounds a burst if charge never completes
        if (CHARGE_DONE_I || count_reg == `TLSF_BURST_MAX_COUNTS)
        begin
          phase_next = TLSF_IDLE;
          done_pulse = 1'b1;
        end
      end
      // unused code: fall back to idle rather than lock up
      default:
      begin
        phase_next = TLSF_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      phase_reg <= TLSF_IDLE;
      step_reg <= '0;
      hb_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      phase_reg <= phase_next;
      step_reg <= step_next;
      hb_reg <= hb_next;
      count_reg <= count_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per trip point: hysteresis comparison and slosh integrator
  // fixed trip points
  localparam tlsf_count_t TRIP [2] = '{`TLSF_LOWER_TRIP_COUNTS, `TLSF_UPPER_TRIP_COUNTS};
  logic [1:0] level;

  for (genvar g = 0; g < 2; g++)
  begin : g_chan
    logic det_reg, det_next;
    logic [CW-1:0] integ_reg, integ_next;
    logic act_reg, act_next;

    always_comb
    begin
      det_next = det_reg;
      integ_next = integ_reg;
      act_next = act_reg;
      if (done_pulse)
      begin
        if (count_reg < TRIP[g] - `TLSF_HYST_COUNTS)
        begin
          det_next = 1'b1;
        end
        else if (count_reg > TRIP[g] + `TLSF_HYST_COUNTS)
        begin
          det_next = 1'b0;
        end
        if (det_next && integ_reg != CW'(INTEG_LIMIT))
        begin
          integ_next = integ_reg + 1'b1;
        end
        else if (!det_next && integ_reg != '0)
        begin
          integ_next = integ_reg - 1'b1;
        end
      end
      // set at limit, clear at zero
      if (integ_next == CW'(INTEG_LIMIT))
      begin
        act_next = 1'b1;
      end
      else if (integ_next == '0)
      begin
        act_next = 1'b0;
      end
    end

    always_ff @(posedge CLK_I)
    begin
      if (SYS_RST_I)
      begin
        det_reg <= 1'b0;
        integ_reg <= '0;
        act_reg <= 1'b0;
      end
      else
      begin
        det_reg <= det_next;
        integ_reg <= integ_next;
        act_reg <= act_next;
      end
    end

    assign level[g] = FILTER_ENABLE_STRAP_I ? act_next : det_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // output pins, registered; straps sampled every cycle
  logic lo_reg;
  logic lo_next;
  logic up_reg;
  logic up_next;
  logic oe_reg;
  logic oe_next;
  logic busy_reg;
  logic busy_next;
  tlsf_count_t shown_reg;
  tlsf_count_t shown_next;

  always_comb
  begin
    lo_next = OUTPUT_POLARITY_STRAP_I ? level[0] : ~level[0];
    up_next = OUTPUT_POLARITY_STRAP_I ? level[1] : ~level[1];
    // release drive
    // float starts on the start edge so the host sees the whole pulse
    oe_next = (phase_next != TLSF_HEALTH);
    busy_next = (phase_next == TLSF_BURST);
    // last burst count stays visible while idle
    shown_next = count_next;
  end

  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I)
    begin
      lo_reg <= 1'b0;
      up_reg <= 1'b0;
      oe_reg <= 1'b0;
      busy_reg <= 1'b0;
      shown_reg <= '0;
    end
    else
    begin
      lo_reg <= lo_next;
      up_reg <= up_next;
      oe_reg <= oe_next;
      busy_reg <= busy_next;
      shown_reg <= shown_next;
    end
  end

  assign LOWER_LEVEL_OUTPUT_O = lo_reg;
  assign UPPER_LEVEL_OUTPUT_O = up_reg;
  assign LOWER_LEVEL_OUTPUT_OE_O = oe_reg;
  assign UPPER_LEVEL_OUTPUT_OE_O = oe_reg;
  assign BURST_ACTIVE_O = busy_reg;
  assign BURST_COUNT_O = shown_reg;

endmodule

// [test/tlsf_load_model.sv]
// host side loads on both level lines
`timescale 1ns/100ps
module tlsf_load_model
(
  input wire logic lower_i,
  input wire logic lower_oe_i,
  input wire logic upper_i,
  input wire logic upper_oe_i,
  output logic lower_line_o,
  output logic upper_line_o,
  output int pulse_count_o = 0
);
  assign lower_line_o = lower_oe_i ? lower_i : 1'b0;
  assign upper_line_o = upper_oe_i ? upper_i : 1'b0;
  // health pulses watched on lower line only
  always @(negedge lower_oe_i)
    pulse_count_o++;
endmodule

// [test/tlsf_top_bench.sv]
// self-checking bench for the level filter
`timescale 1ns/100ps
module tlsf_top_bench;
  logic clk = 1'b0, rst = 1'b1, start = 1'b0, done = 1'b0, filter_enable_strap = 1'b0, output_polarity_strap = 1'b1;
  logic lo, lo_oe, up, up_oe, act, lo_ln, up_ln;
  logic [9:0] cnt;
  int err_count = 0, checks = 0, pulses;
  always #2.5 clk = ~clk;
  tlsf_top #(.INTEG_LIMIT(4), .STEP_CYCLES(2), .HEALTH_CYCLES(4)) u_tlsf_top (.CLK_I(clk), .SYS_RST_I(rst),
    .BURST_START_I(start), .CHARGE_DONE_I(done), .FILTER_ENABLE_STRAP_I(filter_enable_strap), .OUTPUT_POLARITY_STRAP_I(output_polarity_strap),
    .LOWER_LEVEL_OUTPUT_O(lo), .LOWER_LEVEL_OUTPUT_OE_O(lo_oe), .UPPER_LEVEL_OUTPUT_O(up),
    .UPPER_LEVEL_OUTPUT_OE_O(up_oe), .BURST_ACTIVE_O(act), .BURST_COUNT_O(cnt));
  tlsf_load_model u_tlsf_load_model (.lower_i(lo), .lower_oe_i(lo_oe), .upper_i(up), .upper_oe_i(up_oe),
    .lower_line_o(lo_ln), .upper_line_o(up_ln), .pulse_count_o(pulses));
  task automatic stop_test();
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [1:0] got, input logic [1:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %b want %b", $time, got, exp);
    end
  endtask
  // expected lines follow the polarity strap
  task automatic lvl(input logic [1:0] e);
    chk({lo_ln, up_ln}, output_polarity_strap ? e : ~e);
  endtask
  // count 400 is the cap: the burst ends by itself, and done is still driven from act
  task automatic burst(input logic [9:0] c, input logic [1:0] e);
    int n;
    int k;
    n = pulses;
    k = 0;
    @(posedge clk) #1 start = 1'b1;
    @(posedge clk) #1 start = 1'b0;
    @(posedge clk) #1;
    chk({lo_oe, up_oe}, 2'b00);
    while (k < 1000 && !(act && cnt == c) && (act || k < 9))
    begin
      @(posedge clk) #1;
      k++;
    end
    done = act;
    @(posedge clk) #1 done = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(2'(pulses - n), 2'b01);
    lvl(e);
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    burst(10'h0c8, 2'b10);
    burst(10'h0f9, 2'b10);
    burst(10'h0fe, 2'b00);
    burst(10'h064, 2'b11);
    burst(10'h098, 2'b11);
    burst(10'h190, 2'b00);
    @(posedge clk) #1 rst = 1'b1;
    filter_enable_strap = 1'b1;
    @(posedge clk) #1 rst = 1'b0;
    repeat (3) burst(10'h064, 2'b00);
    burst(10'h064, 2'b11);
    burst(10'h0c8, 2'b11);
    repeat (2) burst(10'h12c, 2'b11);
    burst(10'h12c, 2'b10);
    filter_enable_strap = 1'b0;
    repeat (2) @(posedge clk);
    #1 lvl(2'b00);
    output_polarity_strap = 1'b0;
    repeat (2) @(posedge clk);
    #1 lvl(2'b00);
    burst(10'h064, 2'b11);
    stop_test();
  end
  initial
  begin
    #100000;
    err_count++;
    stop_test();
  end
endmodule

// [test/tlsf_top_monitor.sv]
// port checker for the level filter
`timescale 1ns/100ps
module tlsf_top_monitor #(parameter int HEALTH_CYCLES = 4)
(
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic CHARGE_DONE_I,
  input wire logic FILTER_ENABLE_STRAP_I,
  input wire logic OUTPUT_POLARITY_STRAP_I,
  input wire logic LOWER_LEVEL_OUTPUT_O,
  input wire logic LOWER_LEVEL_OUTPUT_OE_O,
  input wire logic UPPER_LEVEL_OUTPUT_OE_O,
  input wire logic BURST_ACTIVE_O,
  input wire logic [9:0] BURST_COUNT_O
);
  wire loe = LOWER_LEVEL_OUTPUT_OE_O;
  wire act = BURST_ACTIVE_O;
  wire [9:0] cnt = BURST_COUNT_O;
  int float_cnt;
  // length of the current float, counted since a plain delay cannot span it
  always_ff @(posedge CLK_I)
  begin
    if (SYS_RST_I || loe)
      float_cnt <= 0;
    else
      float_cnt <= float_cnt + 1;
  end
  default clocking @(posedge CLK_I);
  endclocking
  default disable iff (SYS_RST_I);
  a_float_both: assert property ($fell(loe) |-> !UPPER_LEVEL_OUTPUT_OE_O) else $error("float");
  a_float_length: assert property ($rose(act) |-> float_cnt == HEALTH_CYCLES) else $error("float len");
  a_burst_fresh: assert property ($rose(act) |-> cnt == 10'h000) else $error("start count");
  a_done_ends: assert property (act && CHARGE_DONE_I |=> !act) else $error("done");
  a_count_cap: assert property (cnt <= 10'h190) else $error("cap");
  a_count_step: assert property (act && $past(act) |-> cnt - $past(cnt) <= 10'h001) else $error("step");
  a_count_held: assert property (!act && !$past(act) && loe |-> $stable(cnt)) else $error("held");
  // polarity change inverts the line one cycle later
  a_pol_flip: assert property ($changed(OUTPUT_POLARITY_STRAP_I) && $stable(FILTER_ENABLE_STRAP_I) && !act && loe
    ##1 loe |-> LOWER_LEVEL_OUTPUT_O != $past(LOWER_LEVEL_OUTPUT_O)) else $error("pol");
  c_health: cover property ($fell(loe));
  c_self_end: cover property (cnt == 10'h190);
  c_pol: cover property ($changed(OUTPUT_POLARITY_STRAP_I));
endmodule
bind tlsf_top tlsf_top_monitor #(.HEALTH_CYCLES(HEALTH_CYCLES)) u_tlsf_top_monitor (.*);
